// >>> wpb_map.svh
`ifndef WPB_MAP_SVH
`define WPB_MAP_SVH

// ********************************************************************
// Register offsets (byte addresses).
// ********************************************************************
`define WPB_OFF_CLEAR 12'h000
`define WPB_OFF_SET 12'h004

// ********************************************************************
// Reset value and the mask of bits that hold a flag.
// ********************************************************************
`define WPB_RESET_VAL 32'h0080_0000
`define WPB_FLAG_MASK 32'h013f_fffe

// ********************************************************************
// Field positions and widths.
// ********************************************************************
`define WPB_POS_EVENT 1
`define WPB_POS_SERIAL 2
`define WPB_W_SERIAL 6
`define WPB_POS_CTRL_TMR 8
`define WPB_W_CTRL_TMR 3
`define WPB_POS_GEN_TMR 11
`define WPB_W_GEN_TMR 5
`define WPB_POS_CONVERTER 16
`define WPB_POS_CMP_ZERO 17
`define WPB_POS_OUT_CONV 18
`define WPB_POS_TOUCH 19
`define WPB_POS_AUDIO 20
`define WPB_POS_CMP_ONE 21
`define WPB_POS_CTRL_TMR3 24

// ********************************************************************
// Timing: the slave answers after a fixed number of access cycles.
// ********************************************************************
`define WPB_ACCESS_WAIT 1

`endif

// >>> wpb_pkg.sv
package wpb_pkg;

  typedef logic [31:0] wpb_word_t;

  typedef enum logic [0:0] {
    WPB_IDLE,
    WPB_ANSWER
  } wpb_phase_t;

endpackage

// >>> wpb_flag_if.sv
`timescale 1ns/1ps
`default_nettype none

interface wpb_flag_if;
  wpb_pkg::wpb_word_t set_mask;
  wpb_pkg::wpb_word_t clr_mask;
  wpb_pkg::wpb_word_t flags;

  modport ctrl (
    output set_mask,
    output clr_mask,
    input flags
  );

  modport bank (
    input set_mask,
    input clr_mask,
    output flags
  );
endinterface

`default_nettype wire

// >>> wpb_flag_bank.sv
`timescale 1ns/1ps
`default_nettype none
`include "wpb_map.svh"

module wpb_flag_bank (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic clk_en,
  wpb_flag_if.bank fl
);

  localparam logic [31:0] FLAG_MASK = `WPB_FLAG_MASK;
  localparam logic [31:0] RESET_VAL = `WPB_RESET_VAL;

  // ******************************************************************
  // One cell per bit position.
  // ******************************************************************
  genvar i;
  generate
    for (i = 0; i < 32; i++)
    begin : g_cell
      if (FLAG_MASK[i])
      begin : g_flag
        logic flag_q;
        always_ff @(posedge ref_clk)
        begin
          if (reset)
            flag_q <= RESET_VAL[i];
          else if (clk_en)
          begin
            // RQ10 set wins
            if (fl.set_mask[i])
              flag_q <= 1'b1;
            // RQ2 clear on one
            else if (fl.clr_mask[i])
              flag_q <= 1'b0;
          end
        end
        assign fl.flags[i] = flag_q;
      end
      else
      begin : g_reserved
        // RQ11 reserved is constant
        assign fl.flags[i] = RESET_VAL[i];
      end
    end
  endgenerate

endmodule // wpb_flag_bank

`default_nettype wire

// >>> wpb_protect_bank.sv
// Local design decision: register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "wpb_map.svh"

// Functional notes
// RQ1 - Writing zero to a clear-register flag bit leaves that flag unchanged.
// RQ2 - Writing one to a clear-register flag bit turns protection off.
// RQ3 - A flag bit reads one while protected, zero while not.
// RQ4 - The clear register decodes at byte offset zero.
// RQ5 - The set register decodes at offset four; zeros written there do nothing.
// RQ6 - Bits 11 to 15 hold the five general timer flags, ascending.
// RQ7 - Bits 2 to 7 hold six serial unit flags; bit 1 event router.
// RQ8 - Bits 8 to 10 hold control timers zero to two; bit 24 three.
// RQ9 - Bits 16 to 21 hold converter, comparators, output converter, touch, audio.
// RQ10 - Writing one to a set-register bit enables protection; both read alike.
// RQ11 - Unassigned bit positions ignore writes and are reserved.

module wpb_protect_bank #(
  parameter int ADDR_W = 12
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic event_router_flag,
  output logic [`WPB_W_SERIAL-1:0] serial_unit_flags,
  output logic [`WPB_W_CTRL_TMR-1:0] control_timer_flags,
  output logic [`WPB_W_GEN_TMR-1:0] general_timer_flags,
  output logic converter_flag,
  output logic comparator_pair_zero_flag,
  output logic output_converter_flag,
  output logic touch_controller_flag,
  output logic audio_serial_flag,
  output logic comparator_pair_one_flag,
  output logic control_timer_three_flag
);

  // ******************************************************************
  // Parameter checks.
  // ******************************************************************
  // The decode needs at least the two byte-select bits and bit 2.
  if (ADDR_W < 3)
  begin : g_bad_addr_w
    $error("ADDR_W must be at least 3");
  end

  // ******************************************************************
  // Constants.
  // ******************************************************************
  localparam logic [31:0] FLAG_MASK = `WPB_FLAG_MASK;
  localparam logic [11:0] OFF_CLEAR = `WPB_OFF_CLEAR;
  localparam logic [11:0] OFF_SET = `WPB_OFF_SET;

  // ******************************************************************
  // Decode helpers.
  // ******************************************************************
  // Compares a full bus address with a register byte offset.  Upper
  // address bits beyond the offset width must be zero, so aliases of
  // the two registers elsewhere in the window answer as unmapped.
  function automatic logic addr_hit(
    input logic [ADDR_W-1:0] addr,
    input logic [11:0] off
  );
    logic [ADDR_W+11:0] wide_addr;
    logic [ADDR_W+11:0] wide_off;
    wide_addr = {12'h000, addr};
    wide_off = {{ADDR_W{1'b0}}, off};
    addr_hit = (wide_addr == wide_off);
  endfunction

  // Widens the four byte strobes to a 32-bit lane mask.
  function automatic logic [31:0] lane_mask(input logic [3:0] strb);
    logic [31:0] m;
    m = 32'h0000_0000;
    for (int b = 0; b < 4; b++)
    begin
      m[b*8 +: 8] = {8{strb[b]}};
    end
    lane_mask = m;
  endfunction

  // ******************************************************************
  // Flag bank.
  // ******************************************************************
  wpb_flag_if fl ();

  wpb_flag_bank u_bank (
    .ref_clk (ref_clk),
    .reset (reset),
    .clk_en (clk_en),
    .fl (fl)
  );

  // ******************************************************************
  // Bus decode.
  // ******************************************************************
  wpb_pkg::wpb_phase_t phase_q;
  wpb_pkg::wpb_phase_t phase_d;
  logic pready_q;
  logic pready_d;
  logic pslverr_q;
  logic pslverr_d;
  wpb_pkg::wpb_word_t prdata_q;
  wpb_pkg::wpb_word_t prdata_d;

  wire logic access = psel && penable;
  // RQ4 clear at zero
  wire logic hit_clear = addr_hit(paddr, OFF_CLEAR);
  // RQ5 set at four
  wire logic hit_set = addr_hit(paddr, OFF_SET);
  wire logic hit_any = hit_clear || hit_set;

  // A write takes effect only at the edge where the master sees pready
  // high, so a stalled clock enable cannot commit a write twice.
  wire logic commit = (phase_q == wpb_pkg::WPB_ANSWER) && access
                      && pwrite && hit_any && clk_en;

  // Only the written lanes and only assigned flag positions take part.
  // RQ11 reserved bits masked
  wire wpb_pkg::wpb_word_t write_ones = pwdata & lane_mask(pstrb)
                                        & FLAG_MASK;

  // RQ1 zeros leave flags
  // RQ2 ones clear
  assign fl.clr_mask = (commit && hit_clear) ? write_ones
                                             : 32'h0000_0000;
  // RQ5 zeros ignored
  // RQ10 ones set
  assign fl.set_mask = (commit && hit_set) ? write_ones
                                           : 32'h0000_0000;

  // RQ3 read shows flags
  // RQ10 both read alike
  wire wpb_pkg::wpb_word_t read_word = hit_any ? fl.flags
                                               : 32'h0000_0000;

  // ******************************************************************
  // Bus phase tracking.
  // ******************************************************************
  // Every access gets exactly one wait state: the first access cycle
  // captures read data and the error answer, the second shows pready.
  // The wait state costs a cycle but keeps all outputs registered.
  always_comb
  begin
    phase_d = phase_q;
    pready_d = 1'b0;
    pslverr_d = 1'b0;
    prdata_d = prdata_q;
    case (phase_q)
      wpb_pkg::WPB_IDLE:
      begin
        if (access)
        begin
          phase_d = wpb_pkg::WPB_ANSWER;
          pready_d = 1'b1;
          pslverr_d = !hit_any;
          prdata_d = pwrite ? 32'h0000_0000 : read_word;
        end
      end
      wpb_pkg::WPB_ANSWER:
      begin
        phase_d = wpb_pkg::WPB_IDLE;
        prdata_d = 32'h0000_0000;
      end
      default:
      begin
        phase_d = wpb_pkg::WPB_IDLE;
        prdata_d = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      phase_q <= wpb_pkg::WPB_IDLE;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end
    else if (clk_en)
    begin
      phase_q <= phase_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q <= prdata_d;
    end
  end

  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign prdata = prdata_q;

  // ******************************************************************
  // Per-peripheral protection outputs.
  // ******************************************************************
  // These are the bank's own flip-flops, sliced by field.
  // RQ7 event router bit
  assign event_router_flag = fl.flags[`WPB_POS_EVENT];
  // RQ7 serial units
  assign serial_unit_flags =
    fl.flags[`WPB_POS_SERIAL +: `WPB_W_SERIAL];
  // RQ8 control timers
  assign control_timer_flags =
    fl.flags[`WPB_POS_CTRL_TMR +: `WPB_W_CTRL_TMR];
  // RQ6 general timers
  assign general_timer_flags =
    fl.flags[`WPB_POS_GEN_TMR +: `WPB_W_GEN_TMR];
  // RQ9 analog and misc
  assign converter_flag = fl.flags[`WPB_POS_CONVERTER];
  assign comparator_pair_zero_flag = fl.flags[`WPB_POS_CMP_ZERO];
  assign output_converter_flag = fl.flags[`WPB_POS_OUT_CONV];
  assign touch_controller_flag = fl.flags[`WPB_POS_TOUCH];
  assign audio_serial_flag = fl.flags[`WPB_POS_AUDIO];
  assign comparator_pair_one_flag = fl.flags[`WPB_POS_CMP_ONE];
  // RQ8 control timer three
  assign control_timer_three_flag = fl.flags[`WPB_POS_CTRL_TMR3];

endmodule // wpb_protect_bank

`default_nettype wire

// >>> wpb_protect_bank_checker.sv
`timescale 1ns/1ps
`default_nettype none
`include "wpb_map.svh"
// ****************************************************************
// Bus and flag checks, seen from the top ports.
// ****************************************************************
module wpb_protect_bank_checker #(
  parameter int ADDR_W = 12
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic event_router_flag,
  input wire logic [5:0] serial_unit_flags,
  input wire logic [2:0] control_timer_flags,
  input wire logic [4:0] general_timer_flags,
  input wire logic converter_flag,
  input wire logic comparator_pair_zero_flag,
  input wire logic output_converter_flag,
  input wire logic touch_controller_flag,
  input wire logic audio_serial_flag,
  input wire logic comparator_pair_one_flag,
  input wire logic control_timer_three_flag
);
  logic [31:0] fw;
  logic [31:0] ln;
  logic is_set;
  logic is_clr;
  logic wr_ok;
  // Bit 23 is held at one because the reset word carries it.
  assign fw = {7'h00, control_timer_three_flag, 2'b10,
    comparator_pair_one_flag, audio_serial_flag, touch_controller_flag,
    output_converter_flag, comparator_pair_zero_flag, converter_flag,
    general_timer_flags, control_timer_flags, serial_unit_flags,
    event_router_flag, 1'b0};
  assign ln = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
  assign is_set = paddr == ADDR_W'(`WPB_OFF_SET);
  assign is_clr = paddr == ADDR_W'(`WPB_OFF_CLEAR);
  assign wr_ok = pready && pwrite && !pslverr;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  a_ready_wait: assert property (clk_en && psel && penable && !pready |=> pready)
    else $error("no answer one cycle after access");
  a_err_unmap: assert property (pready && !is_set && !is_clr |-> pslverr)
    else $error("unmapped access not refused");
  a_ok_mapped: assert property (pready && (is_set || is_clr) |-> !pslverr)
    else $error("mapped access refused");
  a_read_word: assert property (pready && !pwrite && !pslverr |-> prdata == fw)
    else $error("read data differs from flag pins");
  a_set_ones: assert property (wr_ok && is_set |=> (fw & `WPB_FLAG_MASK) ==
    (($past(fw) | ($past(pwdata) & $past(ln))) & `WPB_FLAG_MASK))
    else $error("set write gave wrong flags");
  a_clr_ones: assert property (wr_ok && is_clr |=> (fw & `WPB_FLAG_MASK) ==
    (($past(fw) & ~($past(pwdata) & $past(ln))) & `WPB_FLAG_MASK))
    else $error("clear write gave wrong flags");
  a_flags_hold: assert property (!wr_ok |=> $stable(fw))
    else $error("flags moved without a write");
endmodule // wpb_protect_bank_checker
`default_nettype wire

// >>> tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "wpb_map.svh"
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin miscompares++; \
  $display("CHECK FAILED %0t got %h exp %h", $time, a, b); end end
module tb_top;
  logic ref_clk = 1'b0, reset = 1'b1, clk_en = 1'b1, psel = 1'b0;
  logic penable = 1'b0, pwrite = 1'b0, pready, pslverr, ev, c3, f16;
  logic f17, f18, f19, f20, f21, e;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, v, x, pins;
  logic [3:0] pstrb = 4'hf;
  logic [5:0] ser;
  logic [2:0] ct;
  logic [4:0] gt;
  int miscompares = 0, tests_run = 0;
  localparam logic [31:0] RST = `WPB_RESET_VAL;
  localparam logic [31:0] MSK = `WPB_FLAG_MASK;
  assign pins = {7'h00, c3, 2'b10, f21, f20, f19, f18, f17, f16, gt, ct,
    ser, ev, 1'b0};
  always #5 ref_clk = ~ref_clk;
  wpb_protect_bank i_wpb_protect_bank (.ref_clk(ref_clk), .reset(reset),
    .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .event_router_flag(ev),
    .serial_unit_flags(ser), .control_timer_flags(ct),
    .general_timer_flags(gt), .converter_flag(f16),
    .comparator_pair_zero_flag(f17), .output_converter_flag(f18),
    .touch_controller_flag(f19), .audio_serial_flag(f20),
    .comparator_pair_one_flag(f21), .control_timer_three_flag(c3));
  // ****************************************************************
  // Bus access and verdict.
  // ****************************************************************
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge ref_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    v = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Flags move at the edge that ends the access, so look a half later.
    @(negedge ref_clk);
    if (n >= 20)
      miscompares++;
  endtask
  task automatic summarize();
    $display("compares %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // ****************************************************************
  // Scenarios.
  // ****************************************************************
  task automatic t_reset();
    apb(1'b0, `WPB_OFF_CLEAR, 32'h0, 4'hf);
    `CHK(v, RST)
    apb(1'b0, `WPB_OFF_SET, 32'h0, 4'hf);
    `CHK(v, RST)
    `CHK(pins, RST)
  endtask
  task automatic t_walk();
    for (int i = 0; i < 32; i++)
    begin
      x = ((32'h1 << i) & MSK) | RST;
      apb(1'b1, `WPB_OFF_CLEAR, 32'hffff_ffff, 4'hf);
      apb(1'b1, `WPB_OFF_SET, 32'h1 << i, 4'hf);
      `CHK(pins, x)
      apb(1'b0, `WPB_OFF_CLEAR, 32'h0, 4'hf);
      `CHK(v, x)
      apb(1'b0, `WPB_OFF_SET, 32'h0, 4'hf);
      `CHK(v, x)
    end
  endtask
  task automatic t_clear();
    apb(1'b1, `WPB_OFF_SET, 32'hffff_ffff, 4'hf);
    `CHK(pins, MSK | RST)
    apb(1'b1, `WPB_OFF_CLEAR, 32'h0, 4'hf);
    `CHK(pins, MSK | RST)
    apb(1'b1, `WPB_OFF_CLEAR, 32'hff30_0a05, 4'hf);
    x = (MSK & ~32'h0130_0a04) | RST;
    `CHK(pins, x)
    apb(1'b1, `WPB_OFF_SET, 32'h0, 4'hf);
    `CHK(pins, x)
    apb(1'b0, `WPB_OFF_SET, 32'h0, 4'hf);
    `CHK(v, x)
  endtask
  task automatic t_lane_err();
    apb(1'b1, `WPB_OFF_CLEAR, 32'hffff_ffff, 4'hf);
    apb(1'b1, `WPB_OFF_SET, 32'hffff_ffff, 4'h2);
    `CHK(pins, 32'h0000_ff00 | RST)
    apb(1'b1, 12'h008, 32'hffff_ffff, 4'hf);
    `CHK(e, 1'b1)
    apb(1'b0, 12'h804, 32'h0, 4'hf);
    `CHK({e, v}, {1'b1, 32'h0})
    `CHK(pins, 32'h0000_ff00 | RST)
  endtask
  // A held clock enable must stall the bus answer and the flags.
  task automatic t_freeze();
    @(posedge ref_clk);
    clk_en <= 1'b0;
    psel <= 1'b1;
    pwrite <= 1'b1;
    paddr <= `WPB_OFF_SET;
    pwdata <= 32'hffff_ffff;
    pstrb <= 4'hf;
    @(posedge ref_clk);
    penable <= 1'b1;
    repeat (3) @(posedge ref_clk);
    `CHK(pready, 1'b0)
    `CHK(pins, 32'h0000_ff00 | RST)
    clk_en <= 1'b1;
    psel <= 1'b0;
    penable <= 1'b0;
    reset <= 1'b1;
    @(posedge ref_clk);
    reset <= 1'b0;
    @(negedge ref_clk);
    `CHK(pins, RST)
    apb(1'b0, `WPB_OFF_CLEAR, 32'h0, 4'hf);
    `CHK(v, RST)
  endtask
  // Sized from about 600 bus cycles of traffic, with wide margin.
  initial
  begin
    #100us;
    miscompares++;
    summarize();
  end
  initial
  begin
    repeat (5) @(posedge ref_clk);
    reset <= 1'b0;
    t_reset();
    t_walk();
    t_clear();
    t_lane_err();
    t_freeze();
    summarize();
  end
endmodule // tb_top
bind wpb_protect_bank wpb_protect_bank_checker #(.ADDR_W(ADDR_W)) i_chk (
  .ref_clk(ref_clk), .reset(reset), .clk_en(clk_en), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .event_router_flag(event_router_flag),
  .serial_unit_flags(serial_unit_flags),
  .control_timer_flags(control_timer_flags),
  .general_timer_flags(general_timer_flags),
  .converter_flag(converter_flag),
  .comparator_pair_zero_flag(comparator_pair_zero_flag),
  .output_converter_flag(output_converter_flag),
  .touch_controller_flag(touch_controller_flag),
  .audio_serial_flag(audio_serial_flag),
  .comparator_pair_one_flag(comparator_pair_one_flag),
  .control_timer_three_flag(control_timer_three_flag));
`default_nettype wire
